// file: dv/cips_host_model.sv
`default_nettype none
module cips_host_model (
  input wire logic mclk_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // callers enter right after a rising edge; the trailing edge keeps strobes one cycle apart
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    @(posedge mclk_in);
    v = rdata_in;
  endtask
endmodule
`default_nettype wire

// file: dv/cips_seq_properties.sv
`default_nettype none
`include "cips_consts.vh"
module cips_seq_properties #(
  parameter integer BIAS_DELAY_MS = 1,
  parameter integer MS_CYCLES = 1,
  parameter integer INT_CYCLES = 1
) (
  input wire logic mclk_in, rst_n_in, rd_in, vbus_uvlo_ok_in, vbus_above_sleep_in, bat_ocp_in,
  input wire logic sys_above_2v2_in, iin_over_in, battery_switch_out, bias_regulator_out,
  input wire logic high_impedance_mode_out, test_load_out, converter_en_out, chg_reduce_out,
  input wire logic host_interrupt_n_out,
  input wire logic [7:0] rdata_out, ilim_applied_out
);
  int ok_cnt;
  int low_cnt;
  always @(posedge mclk_in) begin
    ok_cnt <= (!rst_n_in || !(vbus_uvlo_ok_in && vbus_above_sleep_in)) ? 0 : ok_cnt + 1;
    low_cnt <= (!rst_n_in || host_interrupt_n_out) ? 0 : low_cnt + 1;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_supply_lost;
    !vbus_uvlo_ok_in [*3];
  endsequence
  // ==========================================
  // power path
  // one ms of slack: the ms divider runs free
  bias_delay_a: assert property ($rose(bias_regulator_out) |-> ok_cnt >= (BIAS_DELAY_MS - 1) * MS_CYCLES)
    else $error("bias on too early");
  supply_lost_a: assert property (s_supply_lost |-> !bias_regulator_out && high_impedance_mode_out)
    else $error("bias kept without supply");
  hiz_bias_a: assert property (high_impedance_mode_out |-> !bias_regulator_out)
    else $error("bias on in high impedance");
  conv_order_a: assert property (converter_en_out |-> bias_regulator_out && !test_load_out)
    else $error("converter out of order");
  load_order_a: assert property (test_load_out |-> bias_regulator_out)
    else $error("test load without bias");
  ocp_open_a: assert property (bat_ocp_in && !vbus_uvlo_ok_in |-> ##[1:2] !battery_switch_out)
    else $error("switch kept on overcurrent");
  ilim_clamp_a: assert property (!sys_above_2v2_in [*3] |-> ilim_applied_out <= `CIPS_ILIM_200MA)
    else $error("limit not clamped");
  reduce_on_a: assert property ((converter_en_out && iin_over_in) [*3] |-> chg_reduce_out)
    else $error("no charge reduction");
  // ==========================================
  // host side
  int_len_a: assert property ($rose(host_interrupt_n_out) |-> low_cnt == INT_CYCLES)
    else $error("interrupt pulse length wrong");
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule
bind cips_sequencer cips_seq_properties #(.BIAS_DELAY_MS(BIAS_DELAY_MS), .MS_CYCLES(MS_CYCLES),
  .INT_CYCLES(INT_CYCLES)) u_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rd_in(rd_in),
  .vbus_uvlo_ok_in(vbus_uvlo_ok_in), .vbus_above_sleep_in(vbus_above_sleep_in), .bat_ocp_in(bat_ocp_in),
  .sys_above_2v2_in(sys_above_2v2_in), .iin_over_in(iin_over_in), .battery_switch_out(battery_switch_out),
  .bias_regulator_out(bias_regulator_out), .high_impedance_mode_out(high_impedance_mode_out),
  .test_load_out(test_load_out), .converter_en_out(converter_en_out), .chg_reduce_out(chg_reduce_out),
  .host_interrupt_n_out(host_interrupt_n_out), .rdata_out(rdata_out), .ilim_applied_out(ilim_applied_out));
`default_nettype wire

// file: dv/cips_sequencer_tb.sv
`default_nettype none
`include "cips_consts.vh"
module cips_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, vu = 0, vs = 0, vmin = 0, depl = 0, ocp = 0, psel = 1, s22 = 1, iov = 0, vun = 0;
  logic ovp = 0, sbb = 0, czero = 0;
  logic [7:0] vcode = 8'h50;
  logic [7:0] d;
  logic [7:0] rst_vals [6] = '{`CIPS_CTRL_RST, `CIPS_ILIM_RST, `CIPS_VLIM_RST, `CIPS_VOFS_RST, 8'h00, 8'h00};
  wire [3:0] addr_in;
  wire [7:0] wdata_in, rdata_out, ilim_out, vlim_out;
  wire wr_in, rd_in, bsw, bias, high_impedance_mode, load, conv, red, int_n;
  int mismatches = 0, check_count = 0, ints = 0, cyc = 0;
  cips_host_model u_host (.mclk_in(mclk_in), .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
    .rd_out(rd_in), .rdata_in(rdata_out));
  cips_sequencer #(.BIAS_DELAY_MS(2), .RETRY_MS(4), .QUAL_MS(1), .MS_CYCLES(10), .INT_CYCLES(4)) u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .vbus_uvlo_ok_in(vu), .vbus_above_sleep_in(vs), .vbus_ovp_in(ovp), .vbus_min_ok_in(vmin),
    .bat_above_depl_in(depl), .bat_ocp_in(ocp), .source_select_pin_in(psel), .sys_above_2v2_in(s22),
    .sys_below_bat_in(sbb), .iin_over_in(iov), .vin_under_in(vun), .chg_current_zero_in(czero),
    .vbus_code_in(vcode), .battery_switch_out(bsw), .bias_regulator_out(bias), .high_impedance_mode_out(high_impedance_mode),
    .test_load_out(load), .converter_en_out(conv), .chg_reduce_out(red), .ilim_applied_out(ilim_out),
    .vlim_applied_out(vlim_out), .host_interrupt_n_out(int_n));
  initial forever #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if ($fell(int_n)) ints <= ints + 1;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc_n(8);
    rst_n_in <= 1'b1;
    cyc_n(1);
    foreach (rst_vals[i]) begin
      u_host.rd(4'(i), d);
      chk(d, rst_vals[i]);
    end
    $display("test reset done");
    depl <= 1'b1;
    cyc_n(3);
    chk({bsw, bias}, 2'b10);
    ocp <= 1'b1;
    cyc_n(2);
    ocp <= 1'b0;
    cyc_n(3);
    chk(bsw, 0);
    $display("test battery done");
    u_host.wr(`CIPS_ADDR_CTRL, 8'h11);
    vu <= 1'b1;
    vs <= 1'b1;
    for (int i = 0; i < 100 && bias !== 1'b1; i++) cyc_n(1);
    cyc_n(2);
    chk({bias, load, high_impedance_mode}, 3'b110);
    cyc_n(15);
    chk({conv, int_n}, 2'b01);
    vmin <= 1'b1;
    ovp <= 1'b1;
    cyc_n(45);
    chk({conv, int_n}, 2'b01);
    ovp <= 1'b0;
    for (int i = 0; i < 300 && conv !== 1'b1; i++) cyc_n(1);
    cyc_n(20);
    chk(ints, 3);
    chk(bsw, 1);
    chk(ilim_out, `CIPS_ILIM_500MA);
    chk(vlim_out, 8'h4a);
    u_host.rd(`CIPS_ADDR_STAT, d);
    chk(d, 8'hcc);
    $display("test attach done");
    u_host.wr(`CIPS_ADDR_VLIM, 8'h30);
    u_host.rd(`CIPS_ADDR_VLIM, d);
    chk(d, 8'h4a);
    u_host.wr(`CIPS_ADDR_CTRL, 8'h19);
    u_host.wr(`CIPS_ADDR_VLIM, 8'h30);
    u_host.rd(`CIPS_ADDR_VLIM, d);
    chk(d, 8'h30);
    u_host.wr(`CIPS_ADDR_ILIM, 8'h14);
    cyc_n(2);
    chk(ilim_out, 8'h14);
    s22 <= 1'b0;
    cyc_n(4);
    chk(ilim_out, `CIPS_ILIM_200MA);
    s22 <= 1'b1;
    iov <= 1'b1;
    cyc_n(4);
    chk(red, 1);
    iov <= 1'b0;
    vun <= 1'b1;
    cyc_n(4);
    u_host.rd(`CIPS_ADDR_STAT, d);
    chk(d, 8'hce);
    vun <= 1'b0;
    u_host.wr(`CIPS_ADDR_CTRL, 8'h09);
    cyc_n(2);
    chk(bsw, 0);
    czero <= 1'b1;
    sbb <= 1'b1;
    iov <= 1'b1;
    cyc_n(3);
    chk(bsw, 1);
    czero <= 1'b0;
    sbb <= 1'b0;
    iov <= 1'b0;
    $display("test limits done");
    psel <= 1'b0;
    u_host.wr(`CIPS_ADDR_CTRL, 8'h1d);
    cyc_n(30);
    u_host.rd(`CIPS_ADDR_CTRL, d);
    chk(d, 8'h19);
    u_host.rd(`CIPS_ADDR_ILIM, d);
    chk(d, `CIPS_ILIM_1500MA);
    u_host.rd(`CIPS_ADDR_STAT, d);
    chk(d, 8'hd0);
    u_host.wr(`CIPS_ADDR_CTRL, 8'h1a);
    cyc_n(4);
    chk({high_impedance_mode, bias, conv}, 3'b100);
    vu <= 1'b0;
    cyc_n(5);
    chk({high_impedance_mode, bias}, 2'b10);
    $display("test detect done");
    rst_n_in <= 1'b0;
    cyc_n(2);
    rst_n_in <= 1'b1;
    cyc_n(1);
    foreach (rst_vals[i]) begin
      u_host.rd(4'(i), d);
      chk(d, rst_vals[i]);
    end
    $display("test mid reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: pkg/cips_consts.vh
`ifndef CIPS_CONSTS_VH
`define CIPS_CONSTS_VH
// ==========================================
// register offsets
`define CIPS_ADDR_CTRL 4'h0
`define CIPS_ADDR_ILIM 4'h1
`define CIPS_ADDR_VLIM 4'h2
`define CIPS_ADDR_VOFS 4'h3
`define CIPS_ADDR_STAT 4'h4
// ==========================================
// control field positions
`define CIPS_CTRL_AUTO 0
`define CIPS_CTRL_HIZ 1
`define CIPS_CTRL_FORCE 2
`define CIPS_CTRL_ABSV 3
`define CIPS_CTRL_CHGEN 4
// ==========================================
// reset values
`define CIPS_CTRL_RST 8'h01
`define CIPS_ILIM_RST 8'h08
`define CIPS_VLIM_RST 8'h2c
`define CIPS_VOFS_RST 8'h06
// ==========================================
// limit codes, 50 ma steps; source type codes
`define CIPS_ILIM_500MA 8'h0a
`define CIPS_ILIM_1500MA 8'h1e
`define CIPS_ILIM_200MA 8'h04
`define CIPS_TYPE_HOST 3'h1
`define CIPS_TYPE_ADAPTER 3'h2
// ==========================================
// timing
`define CIPS_CLK_HZ 25000000
`define CIPS_BIAS_DELAY_MS 220
`define CIPS_RETRY_MS 2000
`define CIPS_QUAL_MS 30
`define CIPS_INT_PULSE_NS 256000
`define CIPS_MS_CYCLES (`CIPS_CLK_HZ / 1000)
`define CIPS_INT_CYCLES (`CIPS_INT_PULSE_NS / 40)
`endif

// file: src/cips_int_pulse.v
`default_nettype none
`include "cips_consts.vh"
// ==========================================
// fixed-length low interrupt pulse
module cips_int_pulse #(
  parameter integer CYCLES = `CIPS_INT_CYCLES
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire fire_in,
  output reg int_n_out
);
  reg [15:0] cnt_q;
  reg [3:0] pend_q;
  // events landing during a pulse are queued, up to 15 pending, so none merge
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0;
      pend_q <= 4'h0;
      int_n_out <= 1'b1;
    end else begin
      if (cnt_q != 16'h0) begin
        cnt_q <= cnt_q - 16'h1;
        if (cnt_q == 16'h1)
          int_n_out <= 1'b1;
        if (fire_in && pend_q != 4'hf)
          pend_q <= pend_q + 4'h1;
      end else if (!int_n_out) begin
        int_n_out <= 1'b1;
      end else if (fire_in || pend_q != 4'h0) begin
        cnt_q <= CYCLES[15:0];
        int_n_out <= 1'b0;
        if (!fire_in)
          pend_q <= pend_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/cips_ms_tick.v
`default_nettype none
`include "cips_consts.vh"
// ==========================================
// millisecond enable divider
module cips_ms_tick #(
  parameter integer CYCLES = `CIPS_MS_CYCLES
) (
  input wire clk_in,
  input wire rst_n_in,
  output reg tick_out
);
  reg [31:0] cnt_q;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: src/cips_sequencer.v
// Implementation choices: strobed register access and the register addresses.
`default_nettype none
`include "cips_consts.vh"
// Functional notes
// RL1 - supply release resets registers, bus ready
// RL2 - battery only: switch on, bias off
// RL3 - discharge overcurrent opens switch until attach
// RL4 - attach sequence runs strictly in order
// RL5 - bias on: uvlo, sleep margin, 220ms
// RL6 - any condition false: high impedance, bias off
// RL7 - qualify: below overvoltage, above minimum loaded
// RL8 - qualified: set good flag, pulse interrupt
// RL9 - failed qualification retries every 2 seconds
// RL10 - auto detect: detect, pulse, limit, good
// RL11 - auto off: detection skipped, fields kept
// RL12 - register value is applied current limit
// RL13 - select pin picks 500ma or 1.5a
// RL14 - host high-z request enters high impedance
// RL15 - force detect reruns, self clears
// RL16 - absolute select: host writes voltage limit
// RL17 - relative select: device computes voltage limit
// RL18 - voltage limit set: pulse interrupt
// RL19 - converter on; switch follows charge enable
// RL20 - low system rail clamps limit 200ma
// RL21 - regulation sets voltage/current active flags
// RL22 - overload below battery closes switch
// RL23 - interrupt is one fixed low pulse
module cips_sequencer #(
  parameter integer BIAS_DELAY_MS = `CIPS_BIAS_DELAY_MS,
  parameter integer RETRY_MS = `CIPS_RETRY_MS,
  parameter integer QUAL_MS = `CIPS_QUAL_MS,
  parameter integer MS_CYCLES = `CIPS_MS_CYCLES,
  parameter integer INT_CYCLES = `CIPS_INT_CYCLES
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire vbus_uvlo_ok_in,
  input wire vbus_above_sleep_in,
  input wire vbus_ovp_in,
  input wire vbus_min_ok_in,
  input wire bat_above_depl_in,
  input wire bat_ocp_in,
  input wire source_select_pin_in,
  input wire sys_above_2v2_in,
  input wire sys_below_bat_in,
  input wire iin_over_in,
  input wire vin_under_in,
  input wire chg_current_zero_in,
  input wire [7:0] vbus_code_in,
  output reg battery_switch_out,
  output reg bias_regulator_out,
  output reg high_impedance_mode_out,
  output reg test_load_out,
  output reg converter_en_out,
  output reg chg_reduce_out,
  output reg [7:0] ilim_applied_out,
  output reg [7:0] vlim_applied_out,
  output reg host_interrupt_n_out
);
  // ==========================================
  // states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_QUAL = 3'h2;
  localparam [2:0] ST_RETRY = 3'h3;
  localparam [2:0] ST_DETECT = 3'h4;
  localparam [2:0] ST_VSET = 3'h5;
  localparam [2:0] ST_RUN = 3'h6;

  wire ms_tick;
  wire int_n;
  reg [2:0] state_q;
  reg [11:0] ms_q;
  reg [7:0] ctrl_q;
  reg [7:0] ilim_q;
  reg [7:0] vlim_q;
  reg [7:0] vofs_q;
  reg [2:0] src_type_q;
  reg input_good_q;
  reg power_good_q;
  reg host_port_q;
  reg speed_q;
  reg vlim_act_q;
  reg ilim_act_q;
  reg ocp_latch_q;
  reg fire_q;
  reg vbus_seen_q;
  reg [7:0] clamp_d;
  reg bias_ok;
  wire hz_req;
  wire attach;

  cips_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_out(ms_tick)
  );

  cips_int_pulse #(.CYCLES(INT_CYCLES)) u_int (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .fire_in(fire_q),
    .int_n_out(int_n)
  );

  assign hz_req = ctrl_q[`CIPS_CTRL_HIZ];
  assign attach = vbus_uvlo_ok_in && !vbus_seen_q;

  always @* begin
    bias_ok = vbus_uvlo_ok_in && vbus_above_sleep_in && !hz_req; // RL5 RL14
  end

  // ==========================================
  // power-up sequence
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE; // RL1
      ms_q <= 12'h0;
      ctrl_q <= `CIPS_CTRL_RST;
      ilim_q <= `CIPS_ILIM_RST;
      vlim_q <= `CIPS_VLIM_RST;
      vofs_q <= `CIPS_VOFS_RST;
      src_type_q <= 3'h0;
      input_good_q <= 1'b0;
      power_good_q <= 1'b0;
      host_port_q <= 1'b0;
      speed_q <= 1'b0;
      fire_q <= 1'b0;
      vbus_seen_q <= 1'b0;
      ocp_latch_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      vbus_seen_q <= vbus_uvlo_ok_in;
      if (bat_ocp_in)
        ocp_latch_q <= 1'b1; // RL3
      else if (attach)
        ocp_latch_q <= 1'b0; // RL3
      if (wr_in) begin
        case (addr_in)
          `CIPS_ADDR_CTRL: ctrl_q <= wdata_in;
          `CIPS_ADDR_ILIM: ilim_q <= wdata_in; // RL12
          `CIPS_ADDR_VLIM: if (ctrl_q[`CIPS_CTRL_ABSV]) vlim_q <= wdata_in; // RL16
          `CIPS_ADDR_VOFS: vofs_q <= wdata_in;
          default: ;
        endcase
      end
      if (!bias_ok) begin
        state_q <= ST_IDLE; // RL6
        ms_q <= 12'h0;
        input_good_q <= 1'b0;
        power_good_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_DELAY; // RL4
            ms_q <= 12'h0;
          end
          ST_DELAY: if (ms_tick) begin
            if (ms_q == BIAS_DELAY_MS - 1) begin
              state_q <= ST_QUAL; // RL5
              ms_q <= 12'h0;
            end else
              ms_q <= ms_q + 12'h1;
          end
          ST_QUAL: if (ms_tick) begin
            if (ms_q == QUAL_MS - 1) begin
              ms_q <= 12'h0;
              if (!vbus_ovp_in && vbus_min_ok_in) begin
                input_good_q <= 1'b1; // RL8
                fire_q <= 1'b1; // RL8
                state_q <= ctrl_q[`CIPS_CTRL_AUTO] ? ST_DETECT : ST_VSET; // RL10 RL11
              end else
                state_q <= ST_RETRY; // RL9
            end else
              ms_q <= ms_q + 12'h1;
          end
          ST_RETRY: if (ms_tick) begin
            if (ms_q == RETRY_MS - 1) begin
              state_q <= ST_QUAL; // RL9
              ms_q <= 12'h0;
            end else
              ms_q <= ms_q + 12'h1;
          end
          ST_DETECT: begin
            if (source_select_pin_in) begin
              ilim_q <= `CIPS_ILIM_500MA; // RL13
              host_port_q <= 1'b1;
              src_type_q <= `CIPS_TYPE_HOST;
              speed_q <= 1'b0;
            end else begin
              ilim_q <= `CIPS_ILIM_1500MA; // RL13
              host_port_q <= 1'b0;
              src_type_q <= `CIPS_TYPE_ADAPTER;
              speed_q <= 1'b1;
            end
            power_good_q <= 1'b1; // RL10
            fire_q <= 1'b1; // RL10
            // a fresh host request in the closing cycle wins over the self-clear
            if (!(wr_in && addr_in == `CIPS_ADDR_CTRL && wdata_in[`CIPS_CTRL_FORCE]))
              ctrl_q[`CIPS_CTRL_FORCE] <= 1'b0; // RL15
            state_q <= (state_q == ST_DETECT && input_good_q && converter_en_out) ? ST_RUN : ST_VSET;
          end
          ST_VSET: begin
            if (!ctrl_q[`CIPS_CTRL_ABSV])
              vlim_q <= vbus_code_in - vofs_q; // RL17
            fire_q <= 1'b1; // RL18
            state_q <= ST_RUN; // RL4
          end
          ST_RUN: begin
            if (ctrl_q[`CIPS_CTRL_FORCE])
              state_q <= ST_DETECT; // RL15
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // limits and power path outputs
  always @* begin
    clamp_d = ilim_q; // RL12
    if (!sys_above_2v2_in && ilim_q > `CIPS_ILIM_200MA)
      clamp_d = `CIPS_ILIM_200MA; // RL20
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      battery_switch_out <= 1'b0;
      bias_regulator_out <= 1'b0;
      high_impedance_mode_out <= 1'b1;
      test_load_out <= 1'b0;
      converter_en_out <= 1'b0;
      chg_reduce_out <= 1'b0;
      ilim_applied_out <= `CIPS_ILIM_RST;
      vlim_applied_out <= `CIPS_VLIM_RST;
      vlim_act_q <= 1'b0;
      ilim_act_q <= 1'b0;
      host_interrupt_n_out <= 1'b1;
      rdata_out <= 8'h0;
    end else begin
      host_interrupt_n_out <= int_n; // RL23
      bias_regulator_out <= bias_ok && state_q != ST_IDLE && state_q != ST_DELAY; // RL5 RL6
      high_impedance_mode_out <= !(bias_ok && state_q != ST_IDLE && state_q != ST_DELAY); // RL6 RL14
      test_load_out <= state_q == ST_QUAL; // RL7
      converter_en_out <= bias_ok && state_q == ST_RUN; // RL19
      ilim_applied_out <= clamp_d; // RL20
      vlim_applied_out <= vlim_q;
      ilim_act_q <= converter_en_out && iin_over_in; // RL21
      vlim_act_q <= converter_en_out && vin_under_in; // RL21
      chg_reduce_out <= converter_en_out && (iin_over_in || vin_under_in); // RL21
      if (ocp_latch_q || bat_ocp_in)
        battery_switch_out <= 1'b0; // RL3
      else if (converter_en_out)
        battery_switch_out <= ctrl_q[`CIPS_CTRL_CHGEN] ||
          (chg_current_zero_in && (iin_over_in || vin_under_in) && sys_below_bat_in); // RL19 RL22
      else
        battery_switch_out <= bat_above_depl_in; // RL2
      rdata_out <= 8'h0;
      if (rd_in) begin
        case (addr_in)
          `CIPS_ADDR_CTRL: rdata_out <= ctrl_q; // RL1
          `CIPS_ADDR_ILIM: rdata_out <= ilim_q;
          `CIPS_ADDR_VLIM: rdata_out <= vlim_q;
          `CIPS_ADDR_VOFS: rdata_out <= vofs_q;
          `CIPS_ADDR_STAT: rdata_out <= {input_good_q, power_good_q, src_type_q,
                                         host_port_q, vlim_act_q, ilim_act_q};
          default: rdata_out <= 8'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
